// File: rtl/adc_params.svh
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit cpu data path with byte addresses on a 32-bit address
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADC_RES_A_HI 32'hffff8420
`define ADC_RES_A_LO 32'hffff8421
`define ADC_RES_B_HI 32'hffff8422
`define ADC_RES_B_LO 32'hffff8423
`define ADC_RES_C_HI 32'hffff8424
`define ADC_RES_C_LO 32'hffff8425
`define ADC_RES_D_HI 32'hffff8426
`define ADC_RES_D_LO 32'hffff8427
`define ADC_CSR_ADDR 32'hffff8428
`define ADC_TRG_ADDR 32'hffff8429

// ----------------------------------------
// control/status and trigger control field positions
// ----------------------------------------
`define ADC_CSR_END_BIT 7
`define ADC_CSR_IE_BIT 6
`define ADC_CSR_START_BIT 5
`define ADC_CSR_SCAN_BIT 4
`define ADC_CSR_SPEED_BIT 3
`define ADC_TRG_EN_BIT 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADC_CSR_RESET 8'h00
`define ADC_TRG_RESET 8'h7f
`define ADC_TRG_FILL 7'h7f
`define ADC_RES_RESET 10'h000

// ----------------------------------------
// conversion lengths in states (clock cycles)
// ----------------------------------------
`define ADC_FIRST_SLOW 9'd266
`define ADC_FIRST_FAST 9'd134
`define ADC_NEXT_SLOW 9'd256
`define ADC_NEXT_FAST 9'd128

`endif

// File: rtl/adc_pkg.sv
// types shared by the converter control block
// assumes adc_params.svh holds every number
package adc_pkg;

    // ----------------------------------------
    // control/status register image
    // ----------------------------------------
    typedef struct packed {
        logic end_flag;      // conversion_end_flag
        logic irq_enable;    // completion_irq_enable
        logic start;         // conversion_start
        logic scan;          // scan mode select
        logic speed_select;  // fast conversion when set
        logic [2:0] input_select;
    } adc_csr_t;

    // ----------------------------------------
    // sequencer states, gray along idle -> conv
    // ----------------------------------------
    typedef enum logic [0:0] {
        ADC_IDLE = 1'b0,
        ADC_CONV = 1'b1
    } adc_state_t;

endpackage

// File: rtl/adc_ctrl.sv
// adc_ctrl: sequencer, registers and result path of the 10-bit converter
// assumes an 8-bit cpu bus on MCLK, a timer trigger pulse and standby level
// on MCLK, and an analog core whose result is valid at conversion end
`include "adc_params.svh"

module adc_ctrl (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic STANDBY,
    input wire logic [31:0] BUS_ADDR,
    input wire logic BUS_RD,
    input wire logic BUS_WR,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    input wire logic TIMER_TRIG,
    output logic CORE_SAMPLE,
    output logic [2:0] CORE_CHAN,
    output logic CORE_FAST,
    input wire logic [9:0] CORE_RESULT,
    output logic COMPLETION_IRQ
);
    import adc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    adc_csr_t csr_r;            // control/status register
    logic trg_en_r;             // timer_trigger_enable
    logic end_seen_r;           // end flag was read as one
    logic [9:0] res_r [4];      // result registers a..d
    logic [7:0] latch_r;        // shared low-byte latch
    logic [7:0] rdata_r;        // read answer
    logic trig_d_r;             // timer trigger, previous cycle
    adc_state_t state_r;        // sequencer state
    logic [8:0] cnt_r;          // states left in conversion
    logic [2:0] chan_r;         // channel being converted
    logic sample_r;             // conversion start pulse to core
    logic irq_r;                // interrupt request

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic wr_csr;               // write to control/status
    logic rd_csr;               // read of control/status
    logic wr_trg;               // write to trigger control
    logic trig_hit;             // accepted timer trigger
    logic conv_end;             // current conversion completes
    logic [2:0] first_chan;     // first channel of scan group
    logic [2:0] last_chan;      // last channel of scan group
    logic pass_done;            // conversion ends a scan pass
    logic [8:0] next_len;       // length of a follow-on scan conversion
    logic [8:0] first_len;      // length of a first conversion

    assign wr_csr = BUS_WR && (BUS_ADDR == `ADC_CSR_ADDR);
    assign rd_csr = BUS_RD && (BUS_ADDR == `ADC_CSR_ADDR);
    assign wr_trg = BUS_WR && (BUS_ADDR == `ADC_TRG_ADDR);
    // pulse edge only, and only while enabled
    assign trig_hit = trg_en_r && TIMER_TRIG && !trig_d_r;
    assign conv_end = (state_r == ADC_CONV) && csr_r.start && (cnt_r == 9'd0);
    // group 0 starts at input 0, group 1 at input 4
    assign first_chan = {csr_r.input_select[2], 2'b00};
    assign last_chan = first_chan + {1'b0, csr_r.input_select[1:0]};
    assign pass_done = (chan_r == last_chan);
    assign first_len = csr_r.speed_select ? `ADC_FIRST_FAST : `ADC_FIRST_SLOW;
    assign next_len = csr_r.speed_select ? `ADC_NEXT_FAST : `ADC_NEXT_SLOW;

    // ----------------------------------------
    // control/status register
    // ----------------------------------------
    // write first, then hardware clears, then hardware sets win
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            csr_r <= adc_csr_t'(`ADC_CSR_RESET);
        end else begin
            if (wr_csr) begin
                csr_r.irq_enable <= BUS_WDATA[`ADC_CSR_IE_BIT];
                csr_r.start <= BUS_WDATA[`ADC_CSR_START_BIT];
                csr_r.scan <= BUS_WDATA[`ADC_CSR_SCAN_BIT];
                csr_r.speed_select <= BUS_WDATA[`ADC_CSR_SPEED_BIT];
                csr_r.input_select <= BUS_WDATA[2:0];
                // writing one to the flag does nothing
                if (!BUS_WDATA[`ADC_CSR_END_BIT] && end_seen_r) begin
                    csr_r.end_flag <= 1'b0;
                end
            end
            // single conversion done: drop busy
            if (conv_end && !csr_r.scan) begin
                csr_r.start <= 1'b0;
            end
            // set wins over clear
            if (conv_end && (!csr_r.scan || pass_done)) begin
                csr_r.end_flag <= 1'b1;
            end
            // timer start acts as a software start
            if (trig_hit) begin
                csr_r.start <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // read-as-one tracking for the end flag
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            end_seen_r <= 1'b0;
        end else if (wr_csr) begin
            end_seen_r <= 1'b0;
        end else if (rd_csr && csr_r.end_flag) begin
            end_seen_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // trigger control register
    // ----------------------------------------
    // only the enable bit is stored; the fill bits are constant ones
    // standby forces the reset value for as long as it is high
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            trg_en_r <= 1'(`ADC_TRG_RESET >> `ADC_TRG_EN_BIT);
        end else if (STANDBY) begin
            // standby entry wipes the enable like a reset
            trg_en_r <= 1'(`ADC_TRG_RESET >> `ADC_TRG_EN_BIT);
        end else if (wr_trg) begin
            trg_en_r <= BUS_WDATA[`ADC_TRG_EN_BIT];
        end
    end

    // ----------------------------------------
    // timer trigger edge memory
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= TIMER_TRIG;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // idle waits for the start bit, conv counts states down to zero
    // the count is loaded with length minus one, so a conversion
    // spans exactly the programmed number of clock cycles
    // hazard: mode and speed are read live, so software must not
    // change them while the start bit is set
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= ADC_IDLE;
            cnt_r <= 9'd0;
            chan_r <= 3'h0;
            sample_r <= 1'b0;
        end else begin
            sample_r <= 1'b0;
            unique case (state_r)
                ADC_IDLE: begin
                    // a new scan start always begins at the group's first input
                    if (csr_r.start) begin
                        state_r <= ADC_CONV;
                        chan_r <= csr_r.scan ? first_chan : csr_r.input_select;
                        cnt_r <= first_len - 9'd1;
                        sample_r <= 1'b1;
                    end
                end
                ADC_CONV: begin
                    if (!csr_r.start) begin
                        // software halt aborts the conversion
                        state_r <= ADC_IDLE;
                    end else if (cnt_r != 9'd0) begin
                        cnt_r <= cnt_r - 9'd1;
                    end else if (!csr_r.scan) begin
                        state_r <= ADC_IDLE;
                    end else begin
                        // next channel, wrap after the last
                        chan_r <= pass_done ? first_chan : chan_r + 3'h1;
                        cnt_r <= next_len - 9'd1;
                        sample_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // result registers, one per channel position
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_res
            always_ff @(posedge MCLK or negedge RST_B) begin
                if (!RST_B) begin
                    res_r[gi] <= `ADC_RES_RESET;
                end else if (conv_end && (chan_r[1:0] == gi[1:0])) begin
                    res_r[gi] <= CORE_RESULT;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // read path and byte latch
    // ----------------------------------------
    // read-only: writes to result addresses are ignored
    // one shared latch serves all four results, so a low-byte
    // read returns the low bits of whichever high byte came last
    // the answer is registered: data stands the cycle after the read
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_r <= 8'h00;
            latch_r <= 8'h00;
        end else if (BUS_RD) begin
            rdata_r <= 8'h00;
            unique case (BUS_ADDR)
                `ADC_RES_A_HI, `ADC_RES_B_HI, `ADC_RES_C_HI, `ADC_RES_D_HI: begin
                    rdata_r <= res_r[BUS_ADDR[2:1]][9:2];
                    latch_r <= {res_r[BUS_ADDR[2:1]][1:0], 6'h00};
                end
                `ADC_RES_A_LO, `ADC_RES_B_LO, `ADC_RES_C_LO, `ADC_RES_D_LO: begin
                    rdata_r <= latch_r;
                end
                `ADC_CSR_ADDR: begin
                    rdata_r <= csr_r;
                end
                `ADC_TRG_ADDR: begin
                    rdata_r <= {trg_en_r, `ADC_TRG_FILL};
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= csr_r.end_flag && csr_r.irq_enable;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign BUS_RDATA = rdata_r;
    assign CORE_SAMPLE = sample_r;
    assign CORE_CHAN = chan_r;
    assign CORE_FAST = csr_r.speed_select;
    assign COMPLETION_IRQ = irq_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    a_single_start_clear: assert property (conv_end && !csr_r.scan && !trig_hit |=> !csr_r.start)
        else $error("start bit not cleared after single conversion");
    a_end_flag_set: assert property (conv_end && (!csr_r.scan || pass_done) |=> csr_r.end_flag)
        else $error("end flag not set at conversion end");
    a_flag_needs_read: assert property (!end_seen_r && csr_r.end_flag && !STANDBY |=> csr_r.end_flag)
        else $error("end flag cleared without prior read");
    a_irq_follows: assert property (csr_r.end_flag && csr_r.irq_enable |=> COMPLETION_IRQ)
        else $error("interrupt missing");
    a_irq_masked: assert property (!csr_r.irq_enable |=> !COMPLETION_IRQ)
        else $error("interrupt while disabled");
    a_busy_start: assert property (state_r == ADC_CONV |-> csr_r.start || $past(wr_csr))
        else $error("converting with start bit low");
    a_trig_ignored: assert property (!trg_en_r && !csr_r.start && !wr_csr |=> !csr_r.start)
        else $error("start set while trigger disabled");
    a_trig_starts: assert property (trig_hit |=> csr_r.start)
        else $error("enabled trigger did not start");
    a_scan_wrap: assert property (conv_end && csr_r.scan && pass_done |=> chan_r == first_chan)
        else $error("scan did not wrap to first channel");
    a_next_length: assert property (conv_end && csr_r.scan |=> cnt_r == next_len - 9'd1)
        else $error("follow-on scan length wrong");
    a_first_length: assert property (state_r == ADC_IDLE && csr_r.start |=> cnt_r == $past(first_len) - 9'd1)
        else $error("first conversion length wrong");
    a_result_store: assert property (conv_end |=> res_r[$past(chan_r[1:0])] == $past(CORE_RESULT))
        else $error("result not stored in its register");
    a_standby_trg: assert property (STANDBY |=> !trg_en_r)
        else $error("trigger enable survived standby");

    c_single_done: cover property (conv_end && !csr_r.scan);
    c_scan_pass: cover property (conv_end && csr_r.scan && pass_done);
    c_trig_start: cover property (trig_hit && state_r == ADC_IDLE);
    c_flag_clear: cover property (wr_csr && end_seen_r && !BUS_WDATA[`ADC_CSR_END_BIT]);
    c_scan_halt: cover property (state_r == ADC_CONV && csr_r.scan && !csr_r.start);

    // ----------------------------------------
    // read path and sequencer checks
    // ----------------------------------------
    // a high-byte read of result a loads its two low bits into the latch
    a_hi_latch: assert property (BUS_RD && BUS_ADDR == `ADC_RES_A_HI |=> latch_r == {$past(res_r[0][1:0]), 6'h00})
        else $error("latch not loaded by high byte read");
    // the low byte answer is the latch as it stood at the read
    a_lo_from_latch: assert property (BUS_RD && BUS_ADDR == `ADC_RES_B_LO |=> BUS_RDATA == $past(latch_r))
        else $error("low byte read not from latch");
    // reserved low bits of every result low byte stay zero
    a_latch_zeros: assert property (latch_r[5:0] == 6'h00)
        else $error("reserved result bits not zero");
    // clearing the start bit halts the sequencer at once
    a_halt_idle: assert property (state_r == ADC_CONV && !csr_r.start |=> state_r == ADC_IDLE)
        else $error("sequencer kept running after halt");
    // a sample pulse lasts one cycle only
    a_sample_pulse: assert property (sample_r |=> !sample_r)
        else $error("sample pulse longer than one cycle");
    // trigger control fill bits always read as ones
    a_trg_fill: assert property (BUS_RD && BUS_ADDR == `ADC_TRG_ADDR |=> BUS_RDATA[6:0] == 7'h7f)
        else $error("trigger control fill bits not one");

endmodule

// File: verif/adc_core_model.sv
// adc_core_model: behavioural analog core facing the control block
// assumes one sample pulse per conversion, all on mclk
module adc_core_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sample,
    input wire logic [2:0] chan,
    input wire logic fast,
    output logic [9:0] result
);
    // ----------------------------------------
    // result latch
    // ----------------------------------------
    // distinct value per input and speed, held until the next sample
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            result <= 10'h3ff;
        end else if (sample) begin
            result <= 10'h2c6 + 10'(chan) * 10'h05b + {9'h000, fast};
        end
    end
endmodule

// File: verif/adc_ctrl_bench.sv
// adc_ctrl_bench: register-level tests of the converter control block
// assumes adc_ctrl with adc_core_model on its core side, 25 MHz clock
`include "adc_params.svh"
module adc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals and bookkeeping
    // ----------------------------------------
    logic mclk, rst_b, standby, bus_rd, bus_wr, timer_trig, irq_q;
    logic [31:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    logic core_sample, core_fast, completion_irq;
    logic [2:0] core_chan;
    logic [9:0] core_result;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t_irq = 0;
    int samp_t[$];
    logic [2:0] samp_ch[$];

    adc_ctrl dut (.MCLK(mclk), .RST_B(rst_b), .STANDBY(standby), .BUS_ADDR(bus_addr), .BUS_RD(bus_rd),
        .BUS_WR(bus_wr), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata), .TIMER_TRIG(timer_trig),
        .CORE_SAMPLE(core_sample), .CORE_CHAN(core_chan), .CORE_FAST(core_fast),
        .CORE_RESULT(core_result), .COMPLETION_IRQ(completion_irq));
    adc_core_model core (.mclk(mclk), .rst_b(rst_b), .sample(core_sample), .chan(core_chan),
        .fast(core_fast), .result(core_result));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // stamps of sample pulses and interrupt rises
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        irq_q <= completion_irq;
        if (core_sample === 1'b1) begin
            samp_t.push_back(cyc);
            samp_ch.push_back(core_chan);
        end
        if (completion_irq === 1'b1 && irq_q !== 1'b1) begin
            t_irq <= cyc;
        end
    end

    // ----------------------------------------
    // compare, bus and wait tasks
    // ----------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask

    // read data lands at the taking edge and is checked 1 ns after it
    task automatic rdc(input logic [31:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        chk8(bus_rdata, exp);
    endtask

    task automatic wait_samples(input int n);
        for (int k = 0; k < 3000 && samp_t.size() < n; k++) @(posedge mclk);
        #1;
        chk_n(samp_t.size(), n);
    endtask

    task automatic wait_irq;
        for (int k = 0; k < 1000 && completion_irq !== 1'b1; k++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic pulse_trig;
        @(posedge mclk);
        timer_trig <= 1'b1;
        @(posedge mclk);
        timer_trig <= 1'b0;
    endtask

    function automatic logic [9:0] res(input int ch, input int f);
        return 10'h2c6 + 10'(ch) * 10'h05b + 10'(f);
    endfunction

    task automatic close_out;
        $display("counts: %0d compared, %0d mismatched", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog, well beyond the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        logic [9:0] r;
        logic [31:0] hi;
        rst_b = 1'b0;
        standby = 1'b0;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        timer_trig = 1'b0;
        bus_addr = 32'h0000_0000;
        bus_wdata = 8'h00;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        // reset values, with one unmapped address last
        for (int i = 0; i < 11; i++) rdc(`ADC_RES_A_HI + 32'(i), (i == 9) ? 8'h7f : 8'h00);
        wr(`ADC_RES_A_HI, 8'hff);
        rdc(`ADC_RES_A_HI, 8'h00);
        $display("test reset and read-only done");
        // single mode, busy bit, flag clearing, irq masked
        wr(`ADC_CSR_ADDR, 8'h2b);
        rdc(`ADC_CSR_ADDR, 8'h2b);
        repeat (200) @(posedge mclk);
        chk8({7'h00, completion_irq}, 8'h00);
        rdc(`ADC_CSR_ADDR, 8'h8b);
        wr(`ADC_CSR_ADDR, 8'h8b);
        wr(`ADC_CSR_ADDR, 8'h0b);
        rdc(`ADC_CSR_ADDR, 8'h8b);
        wr(`ADC_CSR_ADDR, 8'h4b);
        rdc(`ADC_CSR_ADDR, 8'h4b);
        $display("test flag handling done");
        // inputs 0 to 6 in single mode, alternating speed
        for (int ch = 0; ch < 7; ch++) begin
            samp_t = {};
            samp_ch = {};
            wr(`ADC_CSR_ADDR, 8'h60 | 8'((ch % 2) << 3) | 8'(ch));
            wait_irq();
            chk8(8'(samp_ch[0]), 8'(ch));
            chk_n(t_irq - samp_t[0], (ch % 2) ? 135 : 267);
            rdc(`ADC_CSR_ADDR, 8'hc0 | 8'((ch % 2) << 3) | 8'(ch));
            r = res(ch, ch % 2);
            hi = `ADC_RES_A_HI + 32'(2 * (ch % 4));
            rdc(hi, r[9:2]);
            rdc(hi + 32'h1, {r[1:0], 6'h00});
            wr(`ADC_CSR_ADDR, 8'h40);
            @(posedge mclk);
            #1;
            chk8({7'h00, completion_irq}, 8'h00);
        end
        $display("test single channels done");
        // scan of group zero, three inputs, fast
        samp_t = {};
        samp_ch = {};
        wr(`ADC_CSR_ADDR, 8'h7a);
        wait_samples(5);
        rdc(`ADC_CSR_ADDR, 8'hfa);
        wr(`ADC_CSR_ADDR, 8'h4a);
        for (int i = 0; i < 5; i++) chk8(8'(samp_ch[i]), 8'(i % 3));
        for (int i = 1; i < 5; i++) chk_n(samp_t[i] - samp_t[i - 1], (i == 1) ? 134 : 128);
        chk_n(t_irq - samp_t[0], 391);
        repeat (300) @(posedge mclk);
        chk_n(samp_t.size(), 5);
        // scan of group one restarts from its first input
        samp_t = {};
        samp_ch = {};
        wr(`ADC_CSR_ADDR, 8'h3e);
        wait_samples(4);
        wr(`ADC_CSR_ADDR, 8'h0e);
        for (int i = 0; i < 4; i++) chk8(8'(samp_ch[i]), 8'(4 + i % 3));
        $display("test scan done");
        // timer trigger gated, then enabled, then standby
        samp_t = {};
        samp_ch = {};
        pulse_trig();
        repeat (20) @(posedge mclk);
        chk_n(samp_t.size(), 0);
        rdc(`ADC_CSR_ADDR, 8'h8e);
        wr(`ADC_TRG_ADDR, 8'hff);
        rdc(`ADC_TRG_ADDR, 8'hff);
        wr(`ADC_CSR_ADDR, 8'h0d);
        pulse_trig();
        rdc(`ADC_CSR_ADDR, 8'h2d);
        wait_samples(1);
        chk8(8'(samp_ch[0]), 8'h05);
        @(posedge mclk);
        standby <= 1'b1;
        @(posedge mclk);
        standby <= 1'b0;
        rdc(`ADC_TRG_ADDR, 8'h7f);
        $display("test timer trigger done");
        close_out();
    end
endmodule
